// file: btcc_regs.svh
// constants for the basic timer capture/compare block
`ifndef BTCC_REGS_SVH
`define BTCC_REGS_SVH
`define BTCC_CNT_W 16
`define BTCC_NUM_CH 2
`define BTCC_PRE_W 3
`define BTCC_CNT_RST 16'h0000
`define BTCC_CNT_MAX 16'hffff
`define BTCC_CNT_ONE 16'h0001
`endif

// file: btcc_pkg.sv
// types for the basic timer capture/compare block
package btcc_pkg;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY = 2'b11
  } btcc_edge_e;
  typedef enum logic [1:0] {
    CMP_NONE = 2'b00,
    CMP_TOGGLE = 2'b01,
    CMP_CLEAR = 2'b10,
    CMP_SET = 2'b11
  } btcc_cmp_e;
endpackage

// file: btcc_prescaler.sv
// prescaler producing the counter tick from the bus clock
`timescale 1ns/100ps
`include "btcc_regs.svh"
module btcc_prescaler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [`BTCC_PRE_W-1:0] pre_sel_i,
  // tick
  output logic tick_o
);
  logic [6:0] div_ff;
  logic [6:0] nxt_div;
  logic [6:0] mask;

  // divide by 2**pre_sel: tick when all selected low bits are ones
  always_comb
  begin
    mask = 7'((8'h01 << pre_sel_i) - 8'h01);
    nxt_div = run_i ? div_ff + 7'h01 : div_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_ff <= 7'h00;
    else
      div_ff <= nxt_div;
  end

  assign tick_o = run_i && ((div_ff & mask) == mask);
endmodule // btcc_prescaler

// file: btcc_timer.sv
// 16-bit timer with two input capture / output compare channels
`timescale 1ns/100ps
`include "btcc_regs.svh"
// Function
// RULE1: 16-bit up-counter clocked from bus clock through programmable prescaler.
// RULE2: two identical channels, each capture or compare.
// RULE3: capture latches counter on selected edge of channel input.
// RULE4: compare changes output or flags delay when counter matches value.
// RULE5: software accesses counter and channel values as whole words.
// RULE6: in stop state counting does not advance.
// RULE7: in freeze counting pauses only if freeze halt select is one.
// RULE8: in wait counting pauses only if wait halt select is set.
// RULE9: normal counting advances only while run enable is one.
// RULE10: counter wraps from maximum to zero and continues.
module btcc_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // system state
  input wire logic stop_i,
  input wire logic freeze_i,
  input wire logic wait_i,
  // control bits of timer_system_control_one
  input wire logic counter_run_enable_i,
  input wire logic freeze_halt_select_i,
  input wire logic wait_halt_select_i,
  input wire logic [`BTCC_PRE_W-1:0] pre_sel_i,
  // channel configuration
  input wire logic [`BTCC_NUM_CH-1:0] ch_is_cmp_i,
  input wire btcc_pkg::btcc_edge_e ch_edge_i [`BTCC_NUM_CH],
  input wire btcc_pkg::btcc_cmp_e ch_act_i [`BTCC_NUM_CH],
  input wire logic [`BTCC_CNT_W-1:0] ch_cmp_val_i [`BTCC_NUM_CH],
  input wire logic [`BTCC_NUM_CH-1:0] ch_flag_clr_i,
  // channel pins
  input wire logic [`BTCC_NUM_CH-1:0] ch_pin_i,
  output logic [`BTCC_NUM_CH-1:0] ch_pin_o,
  output logic [`BTCC_NUM_CH-1:0] ch_pin_oe_n_o,
  // status
  output logic [`BTCC_CNT_W-1:0] count_o,
  output logic [`BTCC_CNT_W-1:0] ch_cap_o [`BTCC_NUM_CH],
  output logic [`BTCC_NUM_CH-1:0] ch_flag_o
);
  logic run;
  logic tick;
  logic [`BTCC_CNT_W-1:0] cnt_ff;
  logic [`BTCC_NUM_CH-1:0] pin_prev_ff;
  logic prev_ok_ff;
  logic [`BTCC_NUM_CH-1:0] hit;
  logic [`BTCC_NUM_CH-1:0] cap_ev;

  function automatic logic edge_hit(input btcc_pkg::btcc_edge_e sel,
                                    input logic prev, input logic cur);
    case (sel)
      btcc_pkg::EDGE_RISE: edge_hit = !prev && cur;
      btcc_pkg::EDGE_FALL: edge_hit = prev && !cur;
      btcc_pkg::EDGE_ANY: edge_hit = prev != cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // RULE6 RULE7 RULE8 RULE9: run gating
  assign run = counter_run_enable_i && !stop_i && !(freeze_i && freeze_halt_select_i)
               && !(wait_i && wait_halt_select_i);

  // RULE1: prescaled tick
  btcc_prescaler u_pre (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .pre_sel_i(pre_sel_i),
    .tick_o(tick)
  );

  // RULE10: natural 16-bit wrap
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_ff <= `BTCC_CNT_RST;
    else if (tick)
      cnt_ff <= cnt_ff + `BTCC_CNT_ONE;
  end

  // RULE5: whole-word view, updated in one edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_o <= `BTCC_CNT_RST;
    else
      count_o <= cnt_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_prev_ff <= '0;
      prev_ok_ff <= 1'b0;
    end
    else
    begin
      pin_prev_ff <= ch_pin_i;
      prev_ok_ff <= 1'b1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < `BTCC_NUM_CH; i++)
    begin
      // compare fires once per counter step landing on the value
      hit[i] = ch_is_cmp_i[i] && tick && ((cnt_ff + `BTCC_CNT_ONE) == ch_cmp_val_i[i]);
      // history is unknown right after reset: a pin idling high must not look like an edge
      cap_ev[i] = prev_ok_ff && !ch_is_cmp_i[i]
                  && edge_hit(ch_edge_i[i], pin_prev_ff[i], ch_pin_i[i]);
    end
  end

  // RULE3: capture timestamps
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < `BTCC_NUM_CH; i++)
        ch_cap_o[i] <= `BTCC_CNT_RST;
    end
    else
    begin
      for (int i = 0; i < `BTCC_NUM_CH; i++)
        if (cap_ev[i])
          ch_cap_o[i] <= cnt_ff;
    end
  end

  // RULE2: event flags, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ch_flag_o <= '0;
    else
      ch_flag_o <= (ch_flag_o & ~ch_flag_clr_i) | hit | cap_ev;
  end

  // RULE4: output action on match
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ch_pin_o <= '0;
      ch_pin_oe_n_o <= '1;
    end
    else
    begin
      for (int i = 0; i < `BTCC_NUM_CH; i++)
      begin
        ch_pin_oe_n_o[i] <= !(ch_is_cmp_i[i] && ch_act_i[i] != btcc_pkg::CMP_NONE);
        if (hit[i])
        begin
          case (ch_act_i[i])
            btcc_pkg::CMP_TOGGLE: ch_pin_o[i] <= !ch_pin_o[i];
            btcc_pkg::CMP_CLEAR: ch_pin_o[i] <= 1'b0;
            btcc_pkg::CMP_SET: ch_pin_o[i] <= 1'b1;
            default: ch_pin_o[i] <= ch_pin_o[i];
          endcase
        end
      end
    end
  end

  // RULE9: no advance while disabled
  property p_hold_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      !counter_run_enable_i |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("counter moved while disabled"); // RULE9

  // RULE6: stop holds counter
  property p_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
      stop_i |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved in stop"); // RULE6

  // RULE7: freeze halt
  property p_frz;
    @(posedge clk_i) disable iff (!rst_n_i)
      freeze_i && freeze_halt_select_i |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_frz: assert property (p_frz) else $error("counter moved in freeze halt"); // RULE7

  // RULE8: wait halt
  property p_wai;
    @(posedge clk_i) disable iff (!rst_n_i)
      wait_i && wait_halt_select_i |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_wai: assert property (p_wai) else $error("counter moved in wait halt"); // RULE8

  // RULE1: divide by one counts each cycle
  property p_div1;
    @(posedge clk_i) disable iff (!rst_n_i)
      run && pre_sel_i == '0 |=> cnt_ff == $past(cnt_ff) + `BTCC_CNT_ONE;
  endproperty
  a_div1: assert property (p_div1) else $error("counter missed a step"); // RULE1

  // RULE10: wrap to zero
  property p_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
      tick && cnt_ff == `BTCC_CNT_MAX |=> cnt_ff == `BTCC_CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // RULE10

  // RULE3: capture value
  property p_cap;
    @(posedge clk_i) disable iff (!rst_n_i)
      cap_ev[0] |=> ch_cap_o[0] == $past(cnt_ff) && ch_flag_o[0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong"); // RULE3

  // RULE4: set action drives high
  property p_cmp;
    @(posedge clk_i) disable iff (!rst_n_i)
      hit[1] && ch_act_i[1] == btcc_pkg::CMP_SET |=> ch_pin_o[1] && ch_flag_o[1];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare action missing"); // RULE4

  // RULE2: flag not lost on clear
  property p_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      hit[0] && ch_flag_clr_i[0] |=> ch_flag_o[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost on clear"); // RULE2
endmodule // btcc_timer

// file: basic_timer_capture_compare_test.sv
// self-checking bench for the basic timer capture/compare block
`timescale 1ns/100ps
`include "btcc_regs.svh"
module basic_timer_capture_compare_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic stp = 1'b0, frz = 1'b0, wai = 1'b0, en = 1'b0, fsel = 1'b0, wsel = 1'b0;
  logic [2:0] pre = 3'h0;
  logic [1:0] is_cmp = 2'b10, clr = 2'b00, pin = 2'b00, pin_o, oe_n, flag;
  btcc_pkg::btcc_edge_e edg [2];
  btcc_pkg::btcc_cmp_e act [2];
  logic [15:0] cval [2];
  logic [15:0] cap [2];
  logic [15:0] count_o;
  int num_errors = 0, n_compared = 0, cycles = 0;
  btcc_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .stop_i(stp), .freeze_i(frz),
    .wait_i(wai), .counter_run_enable_i(en), .freeze_halt_select_i(fsel),
    .wait_halt_select_i(wsel), .pre_sel_i(pre), .ch_is_cmp_i(is_cmp), .ch_edge_i(edg),
    .ch_act_i(act), .ch_cmp_val_i(cval), .ch_flag_clr_i(clr), .ch_pin_i(pin),
    .ch_pin_o(pin_o), .ch_pin_oe_n_o(oe_n), .count_o(count_o), .ch_cap_o(cap),
    .ch_flag_o(flag));
  always #10 clk_i = ~clk_i;
  // cut a hang short well past the wrap test
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // settle three cycles so the pipeline latency drops out of the delta
  // the window is a whole number of prescaler periods, so the phase drops out too
  task automatic rate(input logic [15:0] exp, input int win);
    logic [15:0] c;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) c = count_o;
    repeat (win) @(negedge clk_i);
    check("count delta", count_o - c, exp);
  endtask
  task automatic t_modes();
    @(posedge clk_i) en <= 1'b1;
    rate(16'h000a, 10);
    @(posedge clk_i) pre <= 3'h1;
    rate(16'h0005, 10);
    @(posedge clk_i) pre <= 3'h2;
    rate(16'h0002, 8);
    @(posedge clk_i) pre <= 3'h7;
    rate(16'h0002, 256);
    @(posedge clk_i) {pre, en} <= 4'h0;
    rate(16'h0000, 10);
    @(posedge clk_i) {en, stp} <= 2'b11;
    rate(16'h0000, 10);
    @(posedge clk_i) {stp, frz} <= 2'b01;
    rate(16'h000a, 10);
    @(posedge clk_i) fsel <= 1'b1;
    rate(16'h0000, 10);
    @(posedge clk_i) {frz, wai} <= 2'b01;
    rate(16'h000a, 10);
    @(posedge clk_i) wsel <= 1'b1;
    rate(16'h0000, 10);
    @(posedge clk_i) wai <= 1'b0;
  endtask
  task automatic t_capture();
    logic [15:0] c;
    @(posedge clk_i) pin[0] <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("cap flag", flag[0], 1'b1);
    c = cap[0];
    @(posedge clk_i) clr[0] <= 1'b1;
    @(posedge clk_i) {clr[0], pin[0]} <= 2'b00;
    repeat (4) @(negedge clk_i);
    check("fall ignored", flag[0], 1'b0);
    repeat (2) @(posedge clk_i);
    pin[0] <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("cap delta", cap[0] - c, 16'h0009);
  endtask
  task automatic cmp_hit(input btcc_pkg::btcc_cmp_e a, input logic exp_pin);
    logic [15:0] c;
    int n;
    @(posedge clk_i)
    begin
      clr <= 2'b10;
      act[1] <= a;
    end
    @(negedge clk_i) c = count_o;
    @(posedge clk_i) {clr, cval[1]} <= {2'b00, c + 16'h0020};
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (flag[1] !== 1'b1 && n < 64);
    // pin and flag change on the edge where the counter lands on the value
    check("cmp flag", flag[1], 1'b1);
    check("cmp pin", pin_o[1], exp_pin);
    check("cmp time", count_o + 16'h0001, c + 16'h0020);
    check("cmp oe_n", oe_n[1], 1'b0);
  endtask
  // roles swapped: channel 0 compares under a held clear, channel 1 captures falls
  task automatic t_swap();
    logic [15:0] c;
    logic [15:0] c0;
    int n;
    @(posedge clk_i)
    begin
      is_cmp <= 2'b01;
      edg <= '{btcc_pkg::EDGE_ANY, btcc_pkg::EDGE_FALL};
      act[0] <= btcc_pkg::CMP_SET;
      pin[1] <= 1'b1;
      clr <= 2'b11;
    end
    @(negedge clk_i)
    begin
      c = count_o;
      c0 = cap[0];
    end
    @(posedge clk_i)
    begin
      clr <= 2'b01;
      cval[0] <= c + 16'h0020;
      pin <= 2'b00;
    end
    repeat (2) @(negedge clk_i);
    check("swap cap", cap[1], c + 16'h0002);
    check("swap flag", flag[1], 1'b1);
    check("swap oe_n", oe_n, 2'b10);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (flag[0] !== 1'b1 && n < 64);
    // the clear is still held when the match lands, so the flag shows for one cycle
    check("set beats clear", flag[0], 1'b1);
    check("swap pin", pin_o[0], 1'b1);
    check("swap time", count_o + 16'h0001, c + 16'h0020);
    check("pin ignored", cap[0], c0);
    @(posedge clk_i)
    begin
      clr <= 2'b11;
      is_cmp <= 2'b00;
      edg[1] <= btcc_pkg::EDGE_OFF;
    end
    @(posedge clk_i)
    begin
      clr <= 2'b00;
      pin <= 2'b11;
    end
    repeat (2) @(negedge clk_i);
    check("any edge", flag[0], 1'b1);
    check("edge off", flag[1], 1'b0);
  endtask
  task automatic t_wrap();
    logic [15:0] c;
    @(negedge clk_i) c = count_o;
    repeat (65536) @(negedge clk_i);
    check("wrap", count_o, c);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    edg = '{btcc_pkg::EDGE_RISE, btcc_pkg::EDGE_OFF};
    act = '{btcc_pkg::CMP_NONE, btcc_pkg::CMP_NONE};
    cval = '{16'h0000, 16'h0000};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    check("reset count", count_o, 16'h0000);
    check("reset oe_n", oe_n, 2'b11);
    t_modes();
    t_capture();
    cmp_hit(btcc_pkg::CMP_SET, 1'b1);
    cmp_hit(btcc_pkg::CMP_CLEAR, 1'b0);
    cmp_hit(btcc_pkg::CMP_TOGGLE, 1'b1);
    t_swap();
    t_wrap();
    finish_test();
  end
endmodule // basic_timer_capture_compare_test
